// File: pkg/pae_defines.svh
// Purpose: constants of the pulse address encoder
// Assumes: mclk at 250 MHz, oscillator period ticks derived below
// Notes: included by the package and the encoder
// How it works
// (RULE_01) message is marker then nine address bits
// (RULE_02) forty low periods after every message
// (RULE_03) message and silence repeat without any command; code waits in silence while the message buffer is full
// (RULE_04) each bit lasts four oscillator periods
// (RULE_05) bit: high, value, value, low
// (RULE_06) marker sent as a one bit
// (RULE_07) tied address input zero, floating input one
// (RULE_08) nine inputs select one of 512 codes
// (RULE_09) test high holds logic, output low
// (RULE_10) after test release forty low periods first
// (RULE_11) external clock may drive oscillator timing
// (RULE_12) outside logic inverts output toward decoder
// (RULE_13) address bits one to nine, sampled per message
// (RULE_14) power-up starts like test release
`ifndef PAE_DEFINES_SVH
`define PAE_DEFINES_SVH

`define PAE_ADDR_BITS   9
`define PAE_MSG_BITS    10
`define PAE_BIT_PERIODS 4
`define PAE_SIL_PERIODS 40
`define PAE_MARKER      1'h1
`define PAE_PH_LAST     2'h3
`define PAE_BIDX_LAST   4'h9
`define PAE_SIL_LAST    6'h27

`define PAE_CLK_HZ      250000000
`define PAE_OSC_HZ      40000
`define PAE_OSC_DIV     (`PAE_CLK_HZ / `PAE_OSC_HZ)

`define PAE_REG_CTRL    4'h0
`define PAE_REG_STATUS  4'h4
`define PAE_REG_ADDR    4'h8
`define PAE_CTRL_EXTOSC 0
`define PAE_CTRL_HOLD   1
`define PAE_CTRL_RST    2'h0

`endif

// File: pkg/pae_pkg.sv
// Purpose: types shared by the pulse address encoder
// Assumes: constants come from pae_defines.svh
// Notes: message bit 0 is the marker, bits 9:1 address inputs 1..9
package pae_pkg;
  `include "pae_defines.svh"

  typedef struct packed {
    logic [`PAE_ADDR_BITS-1:0] addr;
    logic                      marker;
  } pae_msg_t;

  typedef enum logic [1:0] {
    PAE_SILENCE = 2'b01,
    PAE_SEND    = 2'b10
  } pae_state_t;

  typedef struct packed {
    logic       extOsc;
    logic       hold;
  } pae_ctrl_t;
endpackage : pae_pkg

// File: logic/pae_encoder.sv
// Purpose: serial pulse-width address encoder with message stream
// Assumes: pins are asynchronous to mclk and pass two flip-flops
// Notes: output is active-high pulse train; link inverts it outside
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "pae_defines.svh"
module pae_encoder
  import pae_pkg::*;
#(
  parameter int unsigned DIV_W   = 16,
  parameter int unsigned OSC_DIV = `PAE_OSC_DIV
)
(
  input  wire logic                      mclk,      // system clock
  input  wire logic                      rst,       // sync reset, high
  input  wire logic                      testIn,    // test pin, hold
  input  wire logic                      oscIn,     // external osc pin
  input  wire logic [`PAE_ADDR_BITS-1:0] addrIn,    // address pins 1..9
  input  wire logic [3:0]                regAddr,   // register address
  input  wire logic [31:0]               regWdata,  // write data
  input  wire logic                      regWr,     // write strobe
  input  wire logic                      regRd,     // read strobe
  output logic      [31:0]               regRdata,  // read data, +1 cycle
  output logic                           serOut,    // serial pulse output
  output pae_msg_t                       msgData,   // sent message word
  output logic                           msgValid,  // message word valid
  input  wire logic                      msgReady   // consumer ready
);

  function automatic logic regHit(input logic [3:0] a,
                                  input logic [3:0] off);
    regHit = (a == off);
  endfunction : regHit

  // pin synchronisers
  logic                      testMeta_reg;
  logic                      testSync_reg;
  logic                      oscMeta_reg;
  logic                      oscSync_reg;
  logic                      oscPrev_reg;
  logic [`PAE_ADDR_BITS-1:0] addrMeta_reg;
  logic [`PAE_ADDR_BITS-1:0] addrSync_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      testMeta_reg <= 1'h1;
      testSync_reg <= 1'h1;
      oscMeta_reg  <= 1'h0;
      oscSync_reg  <= 1'h0;
      oscPrev_reg  <= 1'h0;
      addrMeta_reg <= '1;
      addrSync_reg <= '1;
    end
    else
    begin
      testMeta_reg <= testIn;
      testSync_reg <= testMeta_reg;
      oscMeta_reg  <= oscIn;
      oscSync_reg  <= oscMeta_reg;
      oscPrev_reg  <= oscSync_reg;
      addrMeta_reg <= addrIn;
      addrSync_reg <= addrMeta_reg;
    end
  end

  // control register
  pae_ctrl_t ctrl_reg;
  pae_ctrl_t ctrl_next;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (regWr && regHit(regAddr, `PAE_REG_CTRL))
    begin
      ctrl_next.extOsc = regWdata[`PAE_CTRL_EXTOSC];
      ctrl_next.hold   = regWdata[`PAE_CTRL_HOLD];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= `PAE_CTRL_RST;
    else
      ctrl_reg <= ctrl_next;
  end

  // oscillator period tick: internal divider or external edge
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             tick;

  always_comb
  begin
    if (ctrl_reg.extOsc)
    begin
      tick     = oscSync_reg & ~oscPrev_reg;  // [RULE_11]
      div_next = '0;
    end
    else
    begin
      tick = (div_reg == DIV_W'(OSC_DIV - 1));
      div_next = tick ? '0 : div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      div_reg <= '0;
    else
      div_reg <= div_next;
  end

  // sequencer
  logic       hold;
  logic       bufFull;
  logic       push;
  pae_state_t state_reg;
  pae_state_t state_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [3:0] bitIdx_reg;
  logic [3:0] bitIdx_next;
  logic [5:0] silCnt_reg;
  logic [5:0] silCnt_next;
  pae_msg_t   msg_reg;
  pae_msg_t   msg_next;
  logic       serOut_reg;
  logic       serOut_next;
  logic       bitVal;

  assign hold   = testSync_reg | ctrl_reg.hold;
  assign bitVal = msg_reg[bitIdx_reg];

  always_comb
  begin
    state_next  = state_reg;
    phase_next  = phase_reg;
    bitIdx_next = bitIdx_reg;
    silCnt_next = silCnt_reg;
    msg_next    = msg_reg;
    serOut_next = serOut_reg;
    push        = 1'h0;
    if (hold)
    begin
      state_next  = PAE_SILENCE;             // [RULE_09] [RULE_10]
      phase_next  = '0;
      bitIdx_next = '0;
      silCnt_next = '0;
      serOut_next = 1'h0;                    // [RULE_09]
    end
    else
    begin
      case (state_reg)
        PAE_SILENCE:
        begin
          serOut_next = 1'h0;                // [RULE_02]
          if (tick)
          begin
            if (silCnt_reg != `PAE_SIL_LAST)
              silCnt_next = silCnt_reg + 6'h1;   // [RULE_02]
            else if (!bufFull)
            begin
              // restart needs no command [RULE_03]
              state_next      = PAE_SEND;
              silCnt_next     = '0;
              phase_next      = '0;
              bitIdx_next     = '0;
              msg_next.marker = `PAE_MARKER;     // [RULE_01] [RULE_06]
              msg_next.addr   = addrSync_reg;    // [RULE_07] [RULE_08] [RULE_13]
              push            = 1'h1;
              serOut_next     = 1'h1;            // [RULE_05]
            end
          end
        end
        PAE_SEND:
        begin
          if (tick)
          begin
            if (phase_reg == `PAE_PH_LAST)   // [RULE_04]
            begin
              phase_next = '0;
              if (bitIdx_reg == `PAE_BIDX_LAST)  // [RULE_01]
              begin
                state_next  = PAE_SILENCE;
                serOut_next = 1'h0;
              end
              else
              begin
                bitIdx_next = bitIdx_reg + 4'h1;
                serOut_next = 1'h1;          // [RULE_05]
              end
            end
            else
            begin
              phase_next  = phase_reg + 2'h1;
              // value for two periods, then low [RULE_05]
              serOut_next = (phase_next == `PAE_PH_LAST) ? 1'h0 : bitVal;
            end
          end
        end
        default:
        begin
          state_next  = PAE_SILENCE;
          serOut_next = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg  <= PAE_SILENCE;             // [RULE_14]
      phase_reg  <= '0;
      bitIdx_reg <= '0;
      silCnt_reg <= '0;
      msg_reg    <= '0;
      serOut_reg <= 1'h0;
    end
    else
    begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      bitIdx_reg <= bitIdx_next;
      silCnt_reg <= silCnt_next;
      msg_reg    <= msg_next;
      serOut_reg <= serOut_next;
    end
  end

  // two-entry message buffer with registered head
  pae_msg_t   mem_reg  [2];
  pae_msg_t   mem_next [2];
  logic       wrPtr_reg;
  logic       wrPtr_next;
  logic       rdPtr_reg;
  logic       rdPtr_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       valid_reg;
  logic       valid_next;
  pae_msg_t   head_reg;
  pae_msg_t   head_next;
  logic       pop;

  assign bufFull = (cnt_reg == 2'h2);
  assign pop     = valid_reg & msgReady;

  always_comb
  begin
    mem_next   = mem_reg;
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    cnt_next   = cnt_reg;
    if (push)
    begin
      mem_next[wrPtr_reg] = msg_next;
      wrPtr_next          = ~wrPtr_reg;
    end
    if (pop)
      rdPtr_next = ~rdPtr_reg;
    cnt_next   = cnt_reg + {1'h0, push} - {1'h0, pop};
    valid_next = (cnt_next != 2'h0);
    head_next  = valid_next ? mem_next[rdPtr_next] : '0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wrPtr_reg  <= 1'h0;
      rdPtr_reg  <= 1'h0;
      cnt_reg    <= 2'h0;
      valid_reg  <= 1'h0;
      head_reg   <= '0;
    end
    else
    begin
      mem_reg    <= mem_next;
      wrPtr_reg  <= wrPtr_next;
      rdPtr_reg  <= rdPtr_next;
      cnt_reg    <= cnt_next;
      valid_reg  <= valid_next;
      head_reg   <= head_next;
    end
  end

  // register read port, data one cycle after the strobe
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = '0;
    if (regRd)
    begin
      if (regHit(regAddr, `PAE_REG_CTRL))
        rdata_next = {30'h0, ctrl_reg.hold, ctrl_reg.extOsc};
      else if (regHit(regAddr, `PAE_REG_STATUS))
        rdata_next = {16'h0, silCnt_reg, bitIdx_reg, phase_reg,
                      bufFull, serOut_reg, hold,
                      (state_reg == PAE_SEND)};
      else if (regHit(regAddr, `PAE_REG_ADDR))
        rdata_next = {22'h0, msg_reg};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign regRdata = rdata_reg;
  assign serOut   = serOut_reg;
  assign msgData  = head_reg;
  assign msgValid = valid_reg;

endmodule : pae_encoder

// File: test/pae_encoder_chk.sv
// Purpose: port checks of pae_encoder
// Assumes: one period tick every OSC_DIV mclk, either source
// Notes: bound below
`timescale 1ns/100ps
module pae_encoder_chk
  import pae_pkg::*;
#(
  parameter int unsigned OSC_DIV = 4
)
(
  input wire logic        mclk,      // clock
  input wire logic        rst,       // reset
  input wire logic        testIn,    // test pin
  input wire logic [3:0]  regAddr,   // address
  input wire logic [31:0] regWdata,  // wdata
  input wire logic        regWr,     // write
  input wire logic        regRd,     // read
  input wire logic [31:0] regRdata,  // rdata
  input wire logic        serOut,    // line
  input wire pae_msg_t    msgData,   // word
  input wire logic        msgValid,  // valid
  input wire logic        msgReady   // ready
);
  logic [15:0] hi_reg, hi_next, lo_reg, lo_next;
  logic        hold_reg, hold_next, seen_reg, seen_next, held;
  // control hold acts like the test pin
  assign held = testIn | hold_reg;
  always_comb
  begin
    hold_next = (regWr && regAddr == 4'h0) ? regWdata[1] : hold_reg;
    hi_next   = serOut ? hi_reg + 16'h1 : 16'h0;
    lo_next   = (serOut || held) ? 16'h0 : lo_reg + 16'h1;
    seen_next = !held && (serOut || seen_reg);
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      {hold_reg, seen_reg, hi_reg, lo_reg} <= '0;
    else
      {hold_reg, seen_reg, hi_reg, lo_reg} <=
        {hold_next, seen_next, hi_next, lo_next};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_pulse;
    !held && $fell(serOut) |-> hi_reg == OSC_DIV || hi_reg == 3 * OSC_DIV;
  endproperty
  property p_gap;
    !held && seen_reg && $rose(serOut) |-> lo_reg == OSC_DIV ||
      lo_reg == 3 * OSC_DIV || (lo_reg >= 41 * OSC_DIV && lo_reg % OSC_DIV == 0);
  endproperty
  property p_first;
    !held && !seen_reg && $rose(serOut) |->
      lo_reg >= 39 * OSC_DIV && lo_reg <= 42 * OSC_DIV;
  endproperty
  property p_test;
    testIn [*4] |-> !serOut;
  endproperty
  property p_idle;
    !regRd |=> regRdata == 32'h0;
  endproperty
  property p_unmap;
    regRd && regAddr != 4'h0 && regAddr != 4'h4 && regAddr != 4'h8
      |=> regRdata == 32'h0;
  endproperty
  property p_marker;
    $rose(msgValid) |-> msgData.marker;
  endproperty
  property p_stall;
    msgValid && !msgReady |=> msgValid && $stable(msgData);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse width");
  a_gap: assert property (p_gap)
    else $error("gap width");
  a_first: assert property (p_first)
    else $error("first low stretch");
  a_test: assert property (p_test)
    else $error("line high in test");
  a_idle: assert property (p_idle)
    else $error("read data not idle");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read");
  a_marker: assert property (p_marker)
    else $error("marker missing");
  a_stall: assert property (p_stall)
    else $error("word lost in stall");
  c_pop: cover property (msgValid && msgReady);
  c_stall: cover property ((msgValid && !msgReady) [*8]);
  c_test: cover property ($fell(testIn));
endmodule : pae_encoder_chk

bind pae_encoder pae_encoder_chk #(.OSC_DIV(OSC_DIV)) u_chk (
  .mclk(mclk), .rst(rst), .testIn(testIn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .serOut(serOut), .msgData(msgData), .msgValid(msgValid),
  .msgReady(msgReady));

// File: test/pae_rx_model.sv
// Purpose: far-end decoder model
// Assumes: inverted line, low while a pulse is sent
// Notes: long pulse is a one
`timescale 1ns/100ps
module pae_rx_model
#(
  parameter int unsigned OSC_DIV = 4
)
(
  input wire logic lineIn,  // inverted line
  input wire logic mclk,    // clock
  input wire logic rst,     // reset
  output logic [9:0] rxWord, // marker at bit 0
  output logic       rxStb   // word done
);
  logic [15:0] run;
  logic [15:0] idle;
  logic [3:0]  nBits;
  logic [9:0]  sh;
  always_ff @(posedge mclk)
  begin
    rxStb <= 1'b0;
    run   <= lineIn ? 16'h0 : run + 16'h1;
    idle  <= lineIn ? idle + 16'h1 : 16'h0;
    // a long quiet line ends any cut frame
    if (idle == 16'(8 * OSC_DIV))
      nBits <= 4'h0;
    if (lineIn && run != 16'h0)
    begin
      sh    <= {run > 16'(2 * OSC_DIV), sh[9:1]};
      nBits <= (nBits == 4'h9) ? 4'h0 : nBits + 4'h1;
      rxStb <= nBits == 4'h9;
      rxWord <= {run > 16'(2 * OSC_DIV), sh[9:1]};
    end
    if (rst)
    begin
      run   <= 16'h0;
      idle  <= 16'h0;
      nBits <= 4'h0;
    end
  end
endmodule : pae_rx_model

// File: test/pae_encoder_test.sv
// Purpose: self-checking bench of pae_encoder
// Assumes: OSC_DIV of 4, external ticks every 4 mclk
// Notes: seeded random addresses and ready
`timescale 1ns/100ps
module pae_encoder_test
  import pae_pkg::*;
;
  localparam int unsigned DIV = 4;
  logic        mclk = 1'b0, rst = 1'b1, testIn = 1'b0, regWr = 1'b0;
  logic        regRd = 1'b0, msgReady = 1'b0, readyOn = 1'b1;
  logic        serOut, msgValid, rxStb;
  logic [8:0]  addrIn = 9'h1ff, na;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [9:0]  rxWord;
  logic [1:0]  oscPh = 2'h0;
  pae_msg_t    msgData;
  pae_msg_t    expQ[$];
  int          fails = 0, checks = 0, cyc = 0, n = 0;
  int          seed = 32'haae36eca;
  pae_encoder #(.OSC_DIV(DIV)) u_dut (
    .mclk(mclk), .rst(rst), .testIn(testIn), .oscIn(oscPh[1]),
    .addrIn(addrIn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .serOut(serOut),
    .msgData(msgData), .msgValid(msgValid), .msgReady(msgReady));
  pae_rx_model #(.OSC_DIV(DIV)) u_rx (.lineIn(~serOut),
    .mclk(mclk), .rst(rst), .rxWord(rxWord), .rxStb(rxStb));
  function automatic pae_msg_t expWord(input logic [8:0] a);
    return '{addr: a, marker: 1'b1};
  endfunction : expWord
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata & m, e);
  endtask : rdc
  task waitRx();
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (rxStb !== 1'b1 && n < 2000);
    if (rxStb !== 1'b1)
      fails++;
  endtask : waitRx
  task holdPin();
    // cut the next message in its marker
    n = 0;
    while (serOut !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    testIn <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({31'h0, serOut}, 32'h0);
    testIn <= 1'b0;
    n = 0;
    while (serOut !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, n >= 39 * DIV && n <= 42 * DIV}, 32'h1);
  endtask : holdPin
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    oscPh <= oscPh + 2'h1;  // external source, one rise per DIV mclk
    if (cyc > 20000)
    begin
      fails++;
      report_and_stop();
    end
    else
    begin
      msgReady <= readyOn && ($random(seed) % 2 != 0);
      if (msgValid === 1'b1 && msgReady === 1'b1)
      begin
        // a newer expectation retires the old one; repeats keep it
        if (expQ.size() > 1)
          void'(expQ.pop_front());
        chk({22'h0, msgData}, {22'h0, expQ[0]});
      end
    end
  end
  initial
  begin
    expQ.push_back(expWord(addrIn));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      waitRx();
      chk({22'h0, rxWord}, {22'h0, expWord(addrIn)});
      if (i == 9)
        rdc(4'h8, 32'h3ff, {22'h0, expWord(addrIn)});
      @(posedge mclk);
      // address moves only in silence, so each word has one value
      na = (i == 0) ? 9'h000 : 9'($random(seed));
      addrIn <= na;
      expQ.push_back(expWord(na));
      if (i == 3)
        holdPin();
      if (i == 5)
      begin
        wr(4'h0, 32'h3);
        rdc(4'h0, 32'h3, 32'h3);
        rdc(4'h4, 32'h2, 32'h2);
        chk({31'h0, serOut}, 32'h0);
        rdc(4'hc, 32'hffffffff, 32'h0);
        wr(4'h0, 32'h1);
      end
      if (i == 7)
      begin
        readyOn <= 1'b0;
        repeat (1200) @(posedge mclk);
        chk({31'h0, msgValid}, 32'h1);
        rdc(4'h4, 32'h8, 32'h8);
        readyOn <= 1'b1;
        repeat (900) @(posedge mclk);
      end
    end
    report_and_stop();
  end
endmodule : pae_encoder_test
